/* File: hw/lpmpc_top.sv */
/*
  Low-power mode policy controller: moves the device between run, sleep,
  stop, standby and shutdown and drives domain power, clock gates and
  oscillator enables. Assumes synchronous inputs, a one-cycle wait pulse
  from the core and wake pulses from the wake logic outside.
*/
// Decided for this implementation: the register addresses and strobed register access.
// What this block does
// - High-speed domain runs from main clock no faster than 80 MHz.
// - High-speed domain powered only in run and sleep.
// - Stop and standby keep CPU, SRAM and peripheral state in retention.
// - Always-on domain powered in every mode but shutdown.
// - Always-on clock capped 40 MHz run/sleep, 4 MHz stop, 32 kHz standby.
// - Deep-sleep flag and power-mode field choose the low-power mode.
// - Run policies: oscillator on, low-frequency main clock, or oscillator off.
// - Stop policies: oscillator full speed, 4 MHz only, or off.
// - Standby policies differ only in the standby clock-stop bit.
// - Sleep gates the CPU clock, keeps run configuration, entered by wait.
// - In stop the always-on clock is forced to the 4 MHz oscillator output.
// - Stop entry turns off PLL, crystal and external high-speed input.
// - Stop and standby policies take effect only on a wait instruction.
// - Standby disables oscillator, fast clocks and ADC, DAC, op amp.
// - Shutdown stops clocks, regulator, brown-out detector, bandgap; loses state.
// - Shutdown ends only on wake pin, debug connection or external reset.
// - Run and sleep policies take effect as soon as written.
// - High-speed timers forced disabled in stop and standby.
`timescale 1ns/10ps
`default_nettype none
module lpmpc_top
#(
  parameter int unsigned MAIN_CLK_HZ = lpmpc_pkg::MAIN_CLK_MAX_HZ
) (
  input  wire logic                         clk_sys,
  input  wire logic                         rst,
  input  wire logic [lpmpc_pkg::ADDR_W-1:0] addr,
  input  wire logic [lpmpc_pkg::DATA_W-1:0] wr_data,
  input  wire logic                         wr_strobe,
  input  wire logic                         rd_strobe,
  output logic      [lpmpc_pkg::DATA_W-1:0] rd_data,
  input  wire logic                         wfi_wfe,
  input  wire logic                         wake_event,
  input  wire logic                         wake_io,
  input  wire logic                         debug_connect,
  input  wire logic                         external_reset_pin,
  output logic                              high_speed_domain_power,
  output logic                              always_on_domain_power,
  output logic                              cpu_clock_enable,
  output logic                              retention_enable,
  output logic                              timer_force_disable,
  output logic                              internal_oscillator_enable,
  output logic                              internal_oscillator_4mhz,
  output logic                              ulp_clock_from_4mhz,
  output logic                              main_clock_low_freq,
  output logic                              system_pll_enable,
  output logic                              high_freq_crystal_enable,
  output logic                              external_high_freq_input_enable,
  output logic      [1:0]                   ultra_low_power_clock_cap,
  output logic                              analog_enable,
  output logic                              standby_clock_stop,
  output logic                              core_regulator_enable,
  output logic                              brownout_detector_enable,
  output logic                              bandgap_enable
);
  import lpmpc_pkg::*;

  // A faster main clock cannot be served by the high-speed domain.
  if (MAIN_CLK_HZ > MAIN_CLK_MAX_HZ) begin : g_bad_clk
    $error("main clock rate above the high-speed domain limit");
  end

  lpmpc_state_t st;
  lpmpc_state_t next_st;

  // Outputs for a mode. Run and sleep read the live policy register so a
  // write acts at once; deeper modes read only the policy taken at entry.
  function automatic lpmpc_out_t drive_outputs(input lpmpc_mode_t m,
                                               input lpmpc_cfg_t  c,
                                               input lpmpc_lat_t  l);
    lpmpc_out_t o;
    o = '0;
    o.aon_power    = 1'b1;
    o.regulator_en = 1'b1;
    o.bor_en       = 1'b1;
    o.bandgap_en   = 1'b1;
    o.analog_en    = 1'b1;
    case (m)
      M_RUN, M_SLEEP: begin
        o.hs_power    = 1'b1;
        o.cpu_clk_en  = (m == M_RUN);
        o.osc_en      = !c.osc_disable;
        o.main_clk_lf = c.osc_disable | c.main_clock_low_freq_select;
        o.pll_en      = 1'b1;
        o.high_freq_crystal_en     = 1'b1;
        o.hfin_en     = 1'b1;
        o.ulp_cap     = ULP_CAP_40MHZ;
      end
      M_STOP: begin
        o.retain         = 1'b1;
        o.timer_disable  = 1'b1;
        // Off wins over the 4 MHz request, which is don't-care then.
        o.osc_en         = !l.osc_off;
        o.osc_run_4mhz   = l.four_meg & !l.osc_off;
        o.ulp_limit_4mhz = 1'b1;
        o.ulp_cap        = ULP_CAP_4MHZ;
      end
      M_STANDBY: begin
        o.retain        = 1'b1;
        o.timer_disable = 1'b1;
        o.analog_en     = 1'b0;
        o.stby_clk_stop = l.stby_clk_stop;
        o.ulp_cap       = ULP_CAP_32KHZ;
      end
      M_SHUTDOWN: begin
        o.aon_power    = 1'b0;
        o.regulator_en = 1'b0;
        o.bor_en       = 1'b0;
        o.bandgap_en   = 1'b0;
        o.analog_en    = 1'b0;
        o.ulp_cap      = ULP_CAP_OFF;
      end
      default: begin
        o.aon_power = 1'b1;
      end
    endcase
    return o;
  endfunction : drive_outputs

  always_comb begin
    next_st = st;
    next_st.rd_data = '0;
    if (wr_strobe && addr == POLICY_CFG_ADDR) begin
      next_st.cfg = lpmpc_cfg_t'(wr_data[CFG_W-1:0]);
    end
    if (rd_strobe) begin
      case (addr)
        POLICY_CFG_ADDR: begin
          next_st.rd_data = {{(DATA_W-CFG_W){1'b0}}, st.cfg};
        end
        MODE_STATUS_ADDR: begin
          next_st.rd_data = {{(DATA_W-MODE_W-LAT_W){1'b0}}, st.lat, st.mode};
        end
        default: begin
          next_st.rd_data = '0;
        end
      endcase
    end
    case (st.mode)
      M_RUN: begin
        // Low-power policies are taken only here, at the wait pulse.
        if (wfi_wfe) begin
          if (!st.cfg.deep_sleep_flag) begin
            next_st.mode = M_SLEEP;
          end else begin
            next_st.lat.four_meg      = st.cfg.four_meg_in_stop_bit;
            next_st.lat.osc_off       = st.cfg.osc_off_in_stop_bit;
            next_st.lat.stby_clk_stop = st.cfg.standby_clock_stop_bit;
            // The unused code 11 leaves the core running.
            case (st.cfg.power_mode_field)
              PMODE_STOP:     next_st.mode = M_STOP;
              PMODE_STANDBY:  next_st.mode = M_STANDBY;
              PMODE_SHUTDOWN: next_st.mode = M_SHUTDOWN;
              default:        next_st.mode = M_RUN;
            endcase
          end
        end
      end
      M_SLEEP, M_STOP, M_STANDBY: begin
        if (wake_event) begin
          next_st.mode = M_RUN;
        end
      end
      M_SHUTDOWN: begin
        if (wake_io || debug_connect || external_reset_pin) begin
          next_st.mode = M_RUN;
          next_st.cfg  = CFG_RST;
          next_st.lat  = '0;
        end
      end
      default: begin
        next_st.mode = M_RUN;
      end
    endcase
    next_st.out = drive_outputs(next_st.mode, next_st.cfg, next_st.lat);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      // Reset leaves the device running under the all-zero run policy.
      st <= '{
        mode:    M_RUN,
        cfg:     CFG_RST,
        lat:     '0,
        out:     {1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0,
                  1'h1, 1'h1, 1'h1, ULP_CAP_40MHZ, 1'h1, 1'h0,
                  1'h1, 1'h1, 1'h1},
        rd_data: '0
      };
    end else begin
      st <= next_st;
    end
  end

  assign rd_data                         = st.rd_data;
  assign high_speed_domain_power         = st.out.hs_power;
  assign always_on_domain_power          = st.out.aon_power;
  assign cpu_clock_enable                = st.out.cpu_clk_en;
  assign retention_enable                = st.out.retain;
  assign timer_force_disable             = st.out.timer_disable;
  assign internal_oscillator_enable      = st.out.osc_en;
  assign internal_oscillator_4mhz        = st.out.osc_run_4mhz;
  assign ulp_clock_from_4mhz             = st.out.ulp_limit_4mhz;
  assign main_clock_low_freq             = st.out.main_clk_lf;
  assign system_pll_enable               = st.out.pll_en;
  assign high_freq_crystal_enable        = st.out.high_freq_crystal_en;
  assign external_high_freq_input_enable = st.out.hfin_en;
  assign ultra_low_power_clock_cap       = st.out.ulp_cap;
  assign analog_enable                   = st.out.analog_en;
  assign standby_clock_stop              = st.out.stby_clk_stop;
  assign core_regulator_enable           = st.out.regulator_en;
  assign brownout_detector_enable        = st.out.bor_en;
  assign bandgap_enable                  = st.out.bandgap_en;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic run_wfi;
  logic deep_wfi;
  assign run_wfi  = (st.mode == M_RUN) && wfi_wfe;
  assign deep_wfi = run_wfi && st.cfg.deep_sleep_flag;

  a_sleep_gates_cpu: assert property (
    run_wfi && !st.cfg.deep_sleep_flag |=>
      !cpu_clock_enable && high_speed_domain_power && st.mode == M_SLEEP)
    else $error("sleep entry did not gate only the CPU clock");

  a_stop_cuts_fast: assert property (
    deep_wfi && st.cfg.power_mode_field == PMODE_STOP |=>
      !high_speed_domain_power && !system_pll_enable &&
      !high_freq_crystal_enable && !external_high_freq_input_enable &&
      ulp_clock_from_4mhz && ultra_low_power_clock_cap == ULP_CAP_4MHZ)
    else $error("stop entry left fast clocks or domain on");

  a_stop_osc_policy: assert property (
    deep_wfi && st.cfg.power_mode_field == PMODE_STOP |=>
      internal_oscillator_enable == !$past(st.cfg.osc_off_in_stop_bit))
    else $error("stop oscillator policy not applied");

  a_standby_slow: assert property (
    deep_wfi && st.cfg.power_mode_field == PMODE_STANDBY |=>
      ultra_low_power_clock_cap == ULP_CAP_32KHZ &&
      !internal_oscillator_enable && !analog_enable &&
      standby_clock_stop == $past(st.cfg.standby_clock_stop_bit))
    else $error("standby clocks or analog not as programmed");

  a_shutdown_off: assert property (
    deep_wfi && st.cfg.power_mode_field == PMODE_SHUTDOWN |=>
      !always_on_domain_power && !core_regulator_enable &&
      !brownout_detector_enable && !bandgap_enable)
    else $error("shutdown left supplies on");

  a_shutdown_hold: assert property (
    st.mode == M_SHUTDOWN && !wake_io && !debug_connect &&
      !external_reset_pin && !wake_event |=> st.mode == M_SHUTDOWN)
    else $error("shutdown left without a wake source");

  a_wake_to_run: assert property (
    (st.mode inside {M_SLEEP, M_STOP, M_STANDBY}) && wake_event |=>
      cpu_clock_enable && high_speed_domain_power &&
      main_clock_low_freq == (st.cfg.osc_disable |
                              st.cfg.main_clock_low_freq_select))
    else $error("wake did not restore run policy");

  a_run_write_now: assert property (
    st.mode == M_RUN && !wfi_wfe && wr_strobe &&
      addr == POLICY_CFG_ADDR && wr_data[7] |=> !internal_oscillator_enable)
    else $error("run policy write not applied at once");

  a_only_wait_leaves: assert property (
    st.mode == M_RUN && !wfi_wfe |=> st.mode == M_RUN)
    else $error("left run mode without a wait instruction");

  a_retain_timers: assert property (
    $rose(retention_enable) |-> timer_force_disable && $past(wfi_wfe) &&
      !high_speed_domain_power)
    else $error("retention without timer disable or wait");

  a_status_read: assert property (
    rd_strobe && addr == MODE_STATUS_ADDR |=>
      rd_data[MODE_W-1:0] == $past(st.mode))
    else $error("status read does not show the mode");

  // Sleep must follow policy writes at once, while the deeper modes must
  // ignore them until the next wait; both halves are checked below.
  a_sleep_write_now: assert property (
    st.mode == M_SLEEP && !wake_event && wr_strobe &&
      addr == POLICY_CFG_ADDR |=>
      internal_oscillator_enable == !$past(wr_data[7]) &&
      main_clock_low_freq == ($past(wr_data[7]) | $past(wr_data[6])) &&
      !cpu_clock_enable)
    else $error("sleep policy write not applied at once");

  a_stop_4mhz_policy: assert property (
    deep_wfi && st.cfg.power_mode_field == PMODE_STOP |=>
      internal_oscillator_4mhz == ($past(st.cfg.four_meg_in_stop_bit) &&
                                   !$past(st.cfg.osc_off_in_stop_bit)))
    else $error("stop 4 MHz policy not applied");

  a_deep_held: assert property (
    st.mode inside {M_STOP, M_STANDBY} && !wake_event |=>
      $stable(st.mode) && $stable(internal_oscillator_enable) &&
      $stable(internal_oscillator_4mhz) && $stable(standby_clock_stop))
    else $error("deep policy changed without a wait instruction");

  a_low_retained: assert property (
    st.mode inside {M_STOP, M_STANDBY} |->
      retention_enable && timer_force_disable && always_on_domain_power &&
      !high_speed_domain_power && !cpu_clock_enable)
    else $error("retention or domains wrong in stop or standby");

  a_shutdown_exit: assert property (
    st.mode == M_SHUTDOWN &&
      (wake_io || debug_connect || external_reset_pin) |=>
      st.mode == M_RUN && st.cfg == CFG_RST && cpu_clock_enable &&
      always_on_domain_power && core_regulator_enable)
    else $error("shutdown exit did not restart with the policy cleared");

  a_sleep_wait_ignored: assert property (
    st.mode == M_SLEEP && wfi_wfe && !wake_event |=> st.mode == M_SLEEP)
    else $error("wait instruction changed the sleep mode");

  a_sleep_keeps_run: assert property (
    st.mode == M_SLEEP |->
      high_speed_domain_power && system_pll_enable &&
      ultra_low_power_clock_cap == ULP_CAP_40MHZ && !cpu_clock_enable)
    else $error("sleep did not keep the run configuration");

  c_sleep: cover property (run_wfi && !st.cfg.deep_sleep_flag);
  c_stop_wake: cover property (st.mode == M_STOP && wake_event);
  c_standby: cover property (st.mode == M_STANDBY && wake_event);
  c_shutdown_exit: cover property (st.mode == M_SHUTDOWN && wake_io);
  c_stop_osc_off: cover property (st.mode == M_STOP &&
                                  !internal_oscillator_enable);

endmodule : lpmpc_top
`default_nettype wire

/* File: hw/lpmpc_pkg.sv */
/*
  Constants, register map and carrier types of the low-power mode policy
  controller. Assumes a single 10 MHz system clock and a plain register port.
*/
`default_nettype none
package lpmpc_pkg;

  localparam int unsigned CLK_SYS_HZ      = 10_000_000;
  localparam int unsigned MAIN_CLK_MAX_HZ = 80_000_000;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CFG_W  = 8;
  localparam int unsigned MODE_W = 3;
  localparam int unsigned LAT_W  = 3;

  localparam logic [ADDR_W-1:0] POLICY_CFG_ADDR  = 8'h00;
  localparam logic [ADDR_W-1:0] MODE_STATUS_ADDR = 8'h04;

  localparam logic [1:0] PMODE_STOP     = 2'h0;
  localparam logic [1:0] PMODE_STANDBY  = 2'h1;
  localparam logic [1:0] PMODE_SHUTDOWN = 2'h2;

  // Cap on the always-on domain clock.
  localparam logic [1:0] ULP_CAP_40MHZ = 2'h0;
  localparam logic [1:0] ULP_CAP_4MHZ  = 2'h1;
  localparam logic [1:0] ULP_CAP_32KHZ = 2'h2;
  localparam logic [1:0] ULP_CAP_OFF   = 2'h3;

  typedef enum logic [MODE_W-1:0] {
    M_RUN, M_SLEEP, M_STOP, M_STANDBY, M_SHUTDOWN
  } lpmpc_mode_t;

  // Bit 7 down to bit 0 of the policy register.
  typedef struct packed {
    logic       osc_disable;
    logic       main_clock_low_freq_select;
    logic       four_meg_in_stop_bit;
    logic       osc_off_in_stop_bit;
    logic       standby_clock_stop_bit;
    logic [1:0] power_mode_field;
    logic       deep_sleep_flag;
  } lpmpc_cfg_t;

  localparam lpmpc_cfg_t CFG_RST = 8'h00;

  // Stop and standby policy taken at the wait instruction.
  typedef struct packed {
    logic four_meg;
    logic osc_off;
    logic stby_clk_stop;
  } lpmpc_lat_t;

  typedef struct packed {
    logic       hs_power;
    logic       aon_power;
    logic       cpu_clk_en;
    logic       retain;
    logic       timer_disable;
    logic       osc_en;
    logic       osc_run_4mhz;
    logic       ulp_limit_4mhz;
    logic       main_clk_lf;
    logic       pll_en;
    logic       high_freq_crystal_en;
    logic       hfin_en;
    logic [1:0] ulp_cap;
    logic       analog_en;
    logic       stby_clk_stop;
    logic       regulator_en;
    logic       bor_en;
    logic       bandgap_en;
  } lpmpc_out_t;

  typedef struct packed {
    lpmpc_mode_t       mode;
    lpmpc_cfg_t        cfg;
    lpmpc_lat_t        lat;
    lpmpc_out_t        out;
    logic [DATA_W-1:0] rd_data;
  } lpmpc_state_t;

endpackage : lpmpc_pkg
`default_nettype wire

/* File: verification/lpmpc_core_model.sv */
/*
  Behavioural model of the processor core beside the policy controller:
  it executes one wait instruction per request, after a chosen stall.
  Assumes the bench raises issue for exactly one cycle per request.
*/
`timescale 1ns/10ps
`default_nettype none
module lpmpc_core_model (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       issue,
  input  wire logic [3:0] stall,
  output logic            wfi_wfe
);
  logic [3:0] cnt;
  logic       pend;

  // A real core may take a while to reach the wait, so the stall varies.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pend    <= 1'h0;
      cnt     <= 4'h0;
      wfi_wfe <= 1'h0;
    end else begin
      wfi_wfe <= 1'h0;
      if (issue) begin
        pend <= 1'h1;
        cnt  <= stall;
      end else if (pend && cnt == 4'h0) begin
        pend    <= 1'h0;
        wfi_wfe <= 1'h1;
      end else if (pend) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule : lpmpc_core_model
`default_nettype wire

/* File: verification/tb.sv */
/*
  Self-checking bench of the low-power mode policy controller with a core
  model issuing wait pulses. Assumes the package and design are compiled.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  import lpmpc_pkg::*;

  logic        clk_sys = 1'h0;
  logic        rst = 1'h1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic        wr_strobe = 1'h0;
  logic        rd_strobe = 1'h0;
  logic        wake_event = 1'h0;
  logic        wake_io = 1'h0;
  logic        debug_connect = 1'h0;
  logic        external_reset_pin = 1'h0;
  logic        issue = 1'h0;
  logic [3:0]  stall = 4'h0;
  logic [31:0] r;
  wire logic   [31:0] rd_data;
  wire logic   wfi_wfe;
  wire lpmpc_out_t seen;
  lpmpc_mode_t m_mode;
  lpmpc_cfg_t  m_cfg;
  lpmpc_lat_t  m_lat;
  int          error_cnt = 0;
  int          n_checks = 0;
  int          seed = 59;
  logic [7:0]  pol [13] = '{8'h00, 8'h40, 8'h80, 8'hc0, 8'hfa, 8'h01, 8'h21,
                            8'h11, 8'h31, 8'h03, 8'h0b, 8'h05, 8'h07};

  always #50 clk_sys = ~clk_sys;

  lpmpc_top lpmpc_top_i (
    .clk_sys(clk_sys), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
    .wfi_wfe(wfi_wfe), .wake_event(wake_event), .wake_io(wake_io),
    .debug_connect(debug_connect), .external_reset_pin(external_reset_pin),
    .high_speed_domain_power(seen.hs_power),
    .always_on_domain_power(seen.aon_power),
    .cpu_clock_enable(seen.cpu_clk_en), .retention_enable(seen.retain),
    .timer_force_disable(seen.timer_disable),
    .internal_oscillator_enable(seen.osc_en),
    .internal_oscillator_4mhz(seen.osc_run_4mhz),
    .ulp_clock_from_4mhz(seen.ulp_limit_4mhz),
    .main_clock_low_freq(seen.main_clk_lf),
    .system_pll_enable(seen.pll_en), .high_freq_crystal_enable(seen.high_freq_crystal_en),
    .external_high_freq_input_enable(seen.hfin_en),
    .ultra_low_power_clock_cap(seen.ulp_cap), .analog_enable(seen.analog_en),
    .standby_clock_stop(seen.stby_clk_stop),
    .core_regulator_enable(seen.regulator_en),
    .brownout_detector_enable(seen.bor_en), .bandgap_enable(seen.bandgap_en)
  );

  lpmpc_core_model lpmpc_core_model_i (
    .clk_sys(clk_sys), .rst(rst), .issue(issue), .stall(stall),
    .wfi_wfe(wfi_wfe)
  );

  function automatic lpmpc_out_t exp_out();
    lpmpc_out_t o;
    logic       rs;
    logic       lp;
    rs = m_mode inside {M_RUN, M_SLEEP};
    lp = m_mode inside {M_STOP, M_STANDBY};
    o = '0;
    o.hs_power = rs;
    o.aon_power = m_mode != M_SHUTDOWN;
    o.cpu_clk_en = m_mode == M_RUN;
    o.retain = lp;
    o.timer_disable = lp;
    o.osc_en = rs ? !m_cfg.osc_disable
                  : (m_mode == M_STOP && !m_lat.osc_off);
    o.osc_run_4mhz = m_mode == M_STOP && m_lat.four_meg && !m_lat.osc_off;
    o.ulp_limit_4mhz = m_mode == M_STOP;
    o.main_clk_lf = rs && (m_cfg.osc_disable
                           || m_cfg.main_clock_low_freq_select);
    o.pll_en = rs;
    o.high_freq_crystal_en = rs;
    o.hfin_en = rs;
    o.ulp_cap = (m_mode == M_STOP) ? ULP_CAP_4MHZ :
                (m_mode == M_STANDBY) ? ULP_CAP_32KHZ :
                (m_mode == M_SHUTDOWN) ? ULP_CAP_OFF : ULP_CAP_40MHZ;
    o.analog_en = !(m_mode inside {M_STANDBY, M_SHUTDOWN});
    o.stby_clk_stop = m_mode == M_STANDBY && m_lat.stby_clk_stop;
    o.regulator_en = m_mode != M_SHUTDOWN;
    o.bor_en = m_mode != M_SHUTDOWN;
    o.bandgap_en = m_mode != M_SHUTDOWN;
    return o;
  endfunction : exp_out

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_checks++;
    if (got !== want) begin
      error_cnt++;
      $display("BAD t=%0t got %h want %h", $time, got, want);
    end
  endtask : chk

  task automatic chk_out();
    chk({13'h0000, seen}, {13'h0000, exp_out()});
  endtask : chk_out

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  task automatic do_reset();
    @(posedge clk_sys);
    rst <= 1'h1;
    repeat (8) @(posedge clk_sys);
    rst <= 1'h0;
    #1;
    m_mode = M_RUN;
    m_cfg = '0;
    m_lat = '0;
    chk_out();
  endtask : do_reset

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_strobe <= 1'h1;
    @(posedge clk_sys);
    wr_strobe <= 1'h0;
    #1;
    if (a == POLICY_CFG_ADDR) m_cfg = d[7:0];
    chk_out();
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] want);
    @(posedge clk_sys);
    addr <= a;
    rd_strobe <= 1'h1;
    @(posedge clk_sys);
    rd_strobe <= 1'h0;
    #1;
    chk(rd_data & m, want & m);
    @(posedge clk_sys);
    #1;
    chk(rd_data, 32'h0);
  endtask : rd

  task automatic rd_status();
    logic [31:0] m;
    m = (m_mode inside {M_STOP, M_STANDBY}) ? 32'hffffffff : 32'hffffffc7;
    rd(MODE_STATUS_ADDR, m, {26'h0, m_lat, m_mode});
  endtask : rd_status

  task automatic wfi(input logic [3:0] s);
    int n;
    @(posedge clk_sys);
    issue <= 1'h1;
    stall <= s;
    @(posedge clk_sys);
    issue <= 1'h0;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wfi_wfe !== 1'h1 && n < 30);
    if (n >= 30) begin
      error_cnt++;
      $display("BAD t=%0t wait pulse never came", $time);
      wrap_up();
    end
    #1;
    if (m_mode == M_RUN) begin
      m_lat = '{m_cfg.four_meg_in_stop_bit, m_cfg.osc_off_in_stop_bit,
                m_cfg.standby_clock_stop_bit};
      if (!m_cfg.deep_sleep_flag) m_mode = M_SLEEP;
      else if (m_cfg.power_mode_field == PMODE_STOP) m_mode = M_STOP;
      else if (m_cfg.power_mode_field == PMODE_STANDBY) m_mode = M_STANDBY;
      else if (m_cfg.power_mode_field == PMODE_SHUTDOWN) m_mode = M_SHUTDOWN;
    end
    chk_out();
  endtask : wfi

  task automatic wake(input int k);
    @(posedge clk_sys);
    case (k)
      0: wake_event <= 1'h1;
      1: wake_io <= 1'h1;
      2: debug_connect <= 1'h1;
      default: external_reset_pin <= 1'h1;
    endcase
    @(posedge clk_sys);
    {wake_event, wake_io, debug_connect, external_reset_pin} <= 4'h0;
    #1;
    if (k == 0 && m_mode inside {M_SLEEP, M_STOP, M_STANDBY}) m_mode = M_RUN;
    if (k != 0 && m_mode == M_SHUTDOWN) begin
      m_mode = M_RUN;
      m_cfg = '0;
      m_lat = '0;
    end
    chk_out();
  endtask : wake

  initial begin
    do_reset();
    rd(POLICY_CFG_ADDR, 32'hffffffff, 32'h0);
    rd_status();
    wr(8'h08, 32'hffffffff);
    rd(8'h08, 32'hffffffff, 32'h0);
    rd(POLICY_CFG_ADDR, 32'hffffffff, 32'h0);
    $display("test registers done");
    foreach (pol[i]) begin
      wr(POLICY_CFG_ADDR, {24'h0, pol[i]});
      rd(POLICY_CFG_ADDR, 32'hffffffff, {24'h0, pol[i]});
      r = $random(seed);
      wfi(r[3:0]);
      wr(POLICY_CFG_ADDR, $random(seed));
      wfi(4'h0);
      rd_status();
      wake(0);
      wake(1 + i % 3);
      $display("test policy %0d done", i);
    end
    for (int j = 0; j < 300; j++) begin
      r = $random(seed);
      if (j == 150) do_reset();
      case (r[2:0])
        3'h0, 3'h1: wr(r[8] ? 8'h08 : POLICY_CFG_ADDR, $random(seed));
        3'h2, 3'h3: wfi(r[12:9]);
        3'h4: wake(int'(r[14:13]));
        3'h5: rd(POLICY_CFG_ADDR, 32'hffffffff, {24'h0, m_cfg});
        default: rd_status();
      endcase
    end
    $display("test random done");
    wrap_up();
  end
endmodule : tb
`default_nettype wire
